/* File: shared/aic_pkg.sv */
// Purpose: Shared constants and types for the input channel config block
// Assumes: Ten-bit write-only config register on a parallel data bus
// Notes:   Selection code is config bits 7..3 as {scan,pair[1:0],pick[1:0]}
package aic_pkg;

  // Register geometry and reset value
  localparam int          AIC_CFG_W      = 10;      // Config register width
  localparam logic [9:0]  AIC_CFG_RESET  = 10'h020; // Pair-count low bit set
  localparam logic [1:0]  AIC_SEL_CFG    = 2'h0;    // Register select code

  // Field positions
  localparam int          AIC_REF_BIT    = 0;       // Reference source
  localparam int          AIC_PD_BIT     = 2;       // Power down
  localparam int          AIC_SEL_LSB    = 3;       // Selection code base
  localparam int          AIC_SEL_W      = 5;       // Selection code width
  localparam int          AIC_TEST_LSB   = 8;       // Test select base
  localparam int          AIC_IDX_W      = 2;       // Sequence index width

  // Selection codes that the hardware knows
  localparam logic [4:0]  AIC_SE_A_POS   = 5'h00;   // Single input_a_pos
  localparam logic [4:0]  AIC_SE_A_NEG   = 5'h01;   // Single input_a_neg
  localparam logic [4:0]  AIC_SE_B_POS   = 5'h02;   // Single input_b_pos
  localparam logic [4:0]  AIC_SE_B_NEG   = 5'h03;   // Single input_b_neg
  localparam logic [4:0]  AIC_DF_A       = 5'h04;   // Single pair A
  localparam logic [4:0]  AIC_DF_B       = 5'h05;   // Single pair B
  localparam logic [4:0]  AIC_SCAN_SE2   = 5'h11;   // Two single inputs
  localparam logic [4:0]  AIC_SCAN_SE3   = 5'h12;   // Three single inputs
  localparam logic [4:0]  AIC_SCAN_SE4   = 5'h13;   // Four single inputs
  localparam logic [4:0]  AIC_SCAN_S1D1  = 5'h15;   // One single, pair B
  localparam logic [4:0]  AIC_SCAN_S2D1  = 5'h16;   // Two single, pair B
  localparam logic [4:0]  AIC_SCAN_D2    = 5'h19;   // Pair A, pair B

  // Analog source picked for one conversion slot
  typedef enum logic [2:0] {
    AIC_IN_A_POS,
    AIC_IN_A_NEG,
    AIC_IN_B_POS,
    AIC_IN_B_NEG,
    AIC_IN_PAIR_A,
    AIC_IN_PAIR_B
  } aic_input_t;

  // Test voltage selection, in field order
  typedef enum logic [1:0] {
    AIC_TEST_NORMAL,
    AIC_TEST_TOP,
    AIC_TEST_MID,
    AIC_TEST_BOTTOM
  } aic_test_t;

  // What the converter core samples in one slot
  typedef struct packed {
    aic_input_t src;   // Source for this slot
    logic       diff;  // Differential measurement
  } aic_slot_t;

endpackage

/* File: src/aic_input_config.sv */
// Purpose: Input config register decode and autoscan channel sequencer
// Assumes: Host writes over the parallel bus; one slot pulse per conversion
// Notes:   Reserved selection codes keep the old selection, other fields load
//
// What this block does
// - Bit 0 picks internal or external reference
// - Bit 2 powers down; register access continues
// - Bits 4:3 form the channel pick field
// - Bits 6:5 pair count, resets to 01
// - Bit 7 turns autoscan on or off
// - Bits 9:8 select internal test voltage
// - Single-ended pick 0..3 selects four inputs
// - Pair count 1 picks pair A or B
// - Scan sequences repeat, one input per slot
// - Scan code 11 cycles a_pos, a_neg
// - Scan code 12 adds b_pos third
// - Scan code 13 cycles all four inputs
// - Scan code 15 alternates a_pos, pair B
// - Scan code 16 cycles a_pos, a_neg, pair B
// - Scan code 19 alternates pair A, pair B
// - Test code gives normal, top, mid, bottom
// - Active-low marker on first scan slot only
`timescale 1ns/1ps
`default_nettype none

module aic_input_config
  import aic_pkg::*;
(
  input  wire logic                 core_clk,          // 250 MHz clock
  input  wire logic                 reset_n,           // Async reset, low
  input  wire logic                 cfgWrite,          // Bus write strobe
  input  wire logic [1:0]           regSel,            // Register select
  input  wire logic [AIC_CFG_W-1:0] dataIn,            // Write data
  input  wire logic                 syncGenClear,      // Sync generator clear
  input  wire logic                 convSlot,          // Conversion slot pulse
  output var  logic                 refExternal,       // External reference
  output var  logic                 powerDown,         // Converter asleep
  output var  aic_test_t            testSel,           // Test voltage choice
  output var  aic_slot_t            slot,              // Slot source
  output var  logic                 multiChannel,      // Scan running
  output var  logic                 firstChannelMark_n // First slot, low
);

  // Length of the sequence for a selection code, zero when reserved
  function automatic logic [2:0] seqLen(input logic [4:0] sel);
    unique case (sel)
      AIC_SE_A_POS, AIC_SE_A_NEG, AIC_SE_B_POS, AIC_SE_B_NEG,
      AIC_DF_A, AIC_DF_B:           seqLen = 3'h1;
      AIC_SCAN_SE2, AIC_SCAN_S1D1,
      AIC_SCAN_D2:                  seqLen = 3'h2;
      AIC_SCAN_SE3, AIC_SCAN_S2D1:  seqLen = 3'h3;
      AIC_SCAN_SE4:                 seqLen = 3'h4;
      default:                      seqLen = 3'h0;
    endcase
  endfunction

  // Source at one position of a sequence
  function automatic aic_input_t seqEntry(input logic [4:0] sel,
                                          input logic [1:0] idx);
    unique case (sel)
      AIC_SE_A_NEG:  seqEntry = AIC_IN_A_NEG;
      AIC_SE_B_POS:  seqEntry = AIC_IN_B_POS;
      AIC_SE_B_NEG:  seqEntry = AIC_IN_B_NEG;
      AIC_DF_A:      seqEntry = AIC_IN_PAIR_A;
      AIC_DF_B:      seqEntry = AIC_IN_PAIR_B;
      AIC_SCAN_SE2, AIC_SCAN_SE3, AIC_SCAN_SE4:
        seqEntry = aic_input_t'({1'b0, idx});
      AIC_SCAN_S1D1:
        seqEntry = (idx == 2'h0) ? AIC_IN_A_POS : AIC_IN_PAIR_B;
      AIC_SCAN_S2D1:
        seqEntry = (idx == 2'h2) ? AIC_IN_PAIR_B
                                 : aic_input_t'({1'b0, idx});
      AIC_SCAN_D2:
        seqEntry = (idx == 2'h0) ? AIC_IN_PAIR_A : AIC_IN_PAIR_B;
      default:       seqEntry = AIC_IN_A_POS;
    endcase
  endfunction

  // Registered state
  logic                 refExt_q;       // Reference source
  logic                 pd_q;           // Power down
  aic_test_t            test_q;         // Test select
  logic [AIC_SEL_W-1:0] sel_q;          // Active selection code
  logic [AIC_IDX_W-1:0] idx_q;          // Next sequence position
  aic_slot_t            slot_q;         // Last issued slot
  logic                 multi_q;        // More than one input
  logic                 mark_n_q;       // First-slot marker

  // Decode of the bus write
  wire                  cfgHit  = cfgWrite && (regSel == AIC_SEL_CFG);
  wire [AIC_SEL_W-1:0]  newSel  = dataIn[AIC_SEL_LSB +: AIC_SEL_W];
  wire                  selOk   = (seqLen(newSel) != 3'h0);
  wire                  selLoad = cfgHit && selOk;
  wire [AIC_SEL_W-1:0]  sel_d   = selLoad ? newSel : sel_q;
  wire [2:0]            curLen  = seqLen(sel_q);
  wire                  multiNow = (curLen > 3'h1);
  wire                  advance = convSlot && !pd_q;
  wire [2:0]            idxInc  = {1'b0, idx_q} + 3'h1;
  wire                  idxWrap = (idxInc >= curLen);

  // Sequence index next value
  wire [AIC_IDX_W-1:0]  idx_d   = (selLoad || syncGenClear) ? '0 :
                                  (advance && idxWrap)      ? '0 :
                                  advance ? idxInc[AIC_IDX_W-1:0] : idx_q;

  // Slot and marker next values
  wire aic_input_t      srcNext = advance ? seqEntry(sel_q, idx_q)
                                          : slot_q.src;
  wire                  diffNext = (srcNext == AIC_IN_PAIR_A) ||
                                   (srcNext == AIC_IN_PAIR_B);
  wire aic_slot_t       slot_d  = '{src: srcNext, diff: diffNext};
  wire                  mark_n_d = !multiNow ? 1'b1 :
                                   advance ? (idx_q != '0) : mark_n_q;

  // Plain config fields, bit 1 ignored
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      refExt_q <= AIC_CFG_RESET[AIC_REF_BIT];
      pd_q     <= AIC_CFG_RESET[AIC_PD_BIT];
      test_q   <= AIC_TEST_NORMAL;
    end else if (cfgHit) begin
      refExt_q <= dataIn[AIC_REF_BIT];
      pd_q     <= dataIn[AIC_PD_BIT];
      test_q   <= aic_test_t'(dataIn[AIC_TEST_LSB +: 2]);
    end
  end

  // Selection code, reserved writes keep the old one
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q   <= AIC_CFG_RESET[AIC_SEL_LSB +: AIC_SEL_W];
      multi_q <= 1'b0;
    end else begin
      sel_q   <= sel_d;
      multi_q <= (seqLen(sel_d) > 3'h1);
    end
  end

  // Sequencer: one source per slot, wraps to the start
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_q    <= '0;
      slot_q   <= '{src: AIC_IN_PAIR_A, diff: 1'b1};
      mark_n_q <= 1'b1;
    end else begin
      idx_q    <= idx_d;
      slot_q   <= slot_d;
      mark_n_q <= mark_n_d;
    end
  end

  // Outputs straight from flops
  assign refExternal       = refExt_q;
  assign powerDown         = pd_q;
  assign testSel           = test_q;
  assign slot              = slot_q;
  assign multiChannel      = multi_q;
  assign firstChannelMark_n = mark_n_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  wire hold = !cfgHit && !syncGenClear;

  property p_ref;
    cfgHit |=> refExternal == $past(dataIn[AIC_REF_BIT]);
  endproperty
  a_ref: assert property (p_ref) else $error("ref select wrong");

  property p_pd;
    cfgHit |=> powerDown == $past(dataIn[AIC_PD_BIT]);
  endproperty
  a_pd: assert property (p_pd) else $error("power down wrong");

  property p_test;
    cfgHit |=> testSel == aic_test_t'($past(dataIn[AIC_TEST_LSB +: 2]));
  endproperty
  a_test: assert property (p_test) else $error("test select wrong");

  property p_scanflag;
    multiChannel == sel_q[4];
  endproperty
  a_scanflag: assert property (p_scanflag) else $error("scan flag");

  property p_single;
    (sel_q == AIC_SE_B_POS && advance) |=> slot.src == AIC_IN_B_POS;
  endproperty
  a_single: assert property (p_single) else $error("single pick");

  property p_pairb;
    (sel_q == AIC_DF_B && advance) |=> (slot.src == AIC_IN_PAIR_B && slot.diff);
  endproperty
  a_pairb: assert property (p_pairb) else $error("pair pick");

  property p_wrap;
    (advance && hold && multiNow && idxWrap) |=> idx_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_four;
    (sel_q == AIC_SCAN_SE4 && advance && hold && idx_q == 2'h3)
      |=> (slot.src == AIC_IN_B_NEG && idx_q == '0);
  endproperty
  a_four: assert property (p_four) else $error("four scan");

  sequence s_mixStart;
    sel_q == AIC_SCAN_S1D1 && advance && hold && idx_q == '0;
  endsequence
  sequence s_nextSlot;
    advance && hold;
  endsequence
  property p_mix;
    s_mixStart ##1 s_nextSlot |=> slot.src == AIC_IN_PAIR_B;
  endproperty
  a_mix: assert property (p_mix) else $error("mixed scan");

  property p_markOn;
    (advance && multiNow && idx_q == '0) |=> !firstChannelMark_n;
  endproperty
  a_markOn: assert property (p_markOn) else $error("marker missing");

  property p_markOff;
    !multiChannel |=> firstChannelMark_n;
  endproperty
  a_markOff: assert property (p_markOff) else $error("marker in single");

  property p_resv;
    (cfgHit && !selOk) |=> $stable(sel_q);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved code loaded");

endmodule

`default_nettype wire

/* File: tb/aic_host_model.sv */
// Purpose: Host processor model that writes the input config register
// Assumes: Strobes are launched at the falling clock edge
// Notes:   A released data bus shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none

module aic_host_model (
  output logic       cfgWrite,     // Write strobe
  output logic [1:0] regSel,       // Register select
  output logic [9:0] dataIn,       // Data bus
  output logic       syncGenClear, // Sync generator clear
  input  wire logic  core_clk      // Bench clock
);
  // Bus idle at time zero
  initial begin
    cfgWrite = 1'b0;
    regSel = 2'h3;
    dataIn = 10'h000;
    syncGenClear = 1'b0;
  end

  // One write cycle, then sync clear after a scan setup
  task automatic wr(input logic [1:0] sel, input logic [9:0] d);
    @(negedge core_clk);
    cfgWrite = 1'b1;
    regSel = sel;
    dataIn = d & 10'h3fd;
    @(negedge core_clk);
    cfgWrite = 1'b0;
    dataIn = ~dataIn;
    syncGenClear = d[7] && sel == 2'h0;
    @(negedge core_clk);
    syncGenClear = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/aic_input_config_tb.sv */
// Purpose: Self-checking bench for the input config decoder
// Assumes: Inputs change at the falling clock edge
// Notes:   Expected slots come from a model of the selection table
`timescale 1ns/1ps
`default_nettype none

module aic_input_config_tb;
  import aic_pkg::*;
  logic        core_clk, reset_n, cfgWrite, syncGenClear, convSlot;
  logic [1:0]  regSel;         // Register select
  logic [9:0]  dataIn;         // Write data
  logic        refExternal, powerDown, multiChannel, firstChannelMark_n;
  aic_test_t   testSel;        // Test voltage
  aic_slot_t   slot;           // Slot source
  int          fails, samples_checked, cycles, mi;
  logic [4:0]  expQ[$];        // Slot and marker notes
  logic [4:0]  lastExp, mc, expCfg;
  logic [31:0] rng;            // Random state
  logic        tookQ, pd;      // Slot seen, model power down
  logic [4:0]  codes[12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                             5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};

  // Clock, 4 ns period
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  aic_host_model i_aic_host_model (.core_clk(core_clk), .cfgWrite(cfgWrite),
    .regSel(regSel), .dataIn(dataIn), .syncGenClear(syncGenClear));
  aic_input_config i_aic_input_config (.core_clk(core_clk), .reset_n(reset_n),
    .cfgWrite(cfgWrite), .regSel(regSel), .dataIn(dataIn),
    .syncGenClear(syncGenClear), .convSlot(convSlot),
    .refExternal(refExternal), .powerDown(powerDown), .testSel(testSel),
    .slot(slot), .multiChannel(multiChannel),
    .firstChannelMark_n(firstChannelMark_n));

  // Entries in one selection's sequence
  function automatic int len(logic [4:0] c);
    case (c)
      5'h12, 5'h16: return 3;
      5'h13: return 4;
      5'h11, 5'h15, 5'h19: return 2;
      default: return 1;
    endcase
  endfunction

  // Source of entry i
  function automatic aic_input_t ent(logic [4:0] c, int i);
    case (c)
      5'h04: return AIC_IN_PAIR_A;
      5'h05: return AIC_IN_PAIR_B;
      5'h15: return i != 0 ? AIC_IN_PAIR_B : AIC_IN_A_POS;
      5'h16: return i == 2 ? AIC_IN_PAIR_B : aic_input_t'(3'(i));
      5'h19: return i != 0 ? AIC_IN_PAIR_B : AIC_IN_PAIR_A;
      5'h11, 5'h12, 5'h13: return aic_input_t'(3'(i));
      default: return aic_input_t'({1'b0, c[1:0]});
    endcase
  endfunction

  // Xorshift step
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Compare and count
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Config write with model update and output check
  task automatic cfg(input logic [1:0] sel, input logic [9:0] d);
    i_aic_host_model.wr(sel, d);
    if (sel == 2'h0) begin
      pd = d[2];
      if (len(d[7:3]) > 1 || d[7:3] < 5'h06) begin
        mc = d[7:3];
        mi = 0;
      end
      if (d[7])
        mi = 0;
      expCfg = {d[0], d[2], d[9:8], len(mc) > 1};
    end
    chk({refExternal, powerDown, testSel, multiChannel}, expCfg);
  endtask

  // Slot pulses, one note each; burst keeps the strobe up every cycle
  task automatic slots(int n, bit burst = 1'b0);
    aic_input_t e;
    repeat (n) begin
      @(negedge core_clk);
      convSlot = 1'b1;
      if (!pd) begin
        e = ent(mc, mi);
        lastExp = {e, e >= AIC_IN_PAIR_A, !(len(mc) > 1 && mi == 0)};
        mi = (mi + 1) % len(mc);
      end
      expQ.push_back(lastExp);
      if (!burst) begin
        @(negedge core_clk);
        convSlot = 1'b0;
      end
    end
    if (burst) begin
      @(negedge core_clk);
      convSlot = 1'b0;
    end
  endtask

  // Result watcher
  always @(posedge core_clk)
    tookQ <= convSlot;
  always @(negedge core_clk)
    if (tookQ && reset_n)
      chk({slot, firstChannelMark_n}, expQ.pop_front());
  // Hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    convSlot = 1'b0;
    pd = 1'b0;
    mc = 5'h04;
    mi = 0;
    rng = 32'h6058;
    lastExp = {AIC_IN_PAIR_A, 2'b11};
    expCfg = 5'h00;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    chk({refExternal, powerDown, testSel, multiChannel}, 5'h00);
    slots(2);
    foreach (codes[k]) begin
      rng = xs(rng);
      cfg(2'h0, {2'(k % 4), codes[k], 1'b0, rng[1:0]});
      slots(2 * len(codes[k]) + 1, k[0]);
    end
    cfg(2'h1, 10'h0a3);
    slots(1);
    cfg(2'h0, 10'h098);
    slots(1);
    cfg(2'h0, 10'h03d);
    slots(2);
    cfg(2'h0, 10'h038);
    slots(4);
    cfg(2'h0, 10'h080);
    slots(2);
    close_out();
  end
endmodule
`default_nettype wire
